// ---- rtl/fac_fault_address_capture.sv ----
// Fault address capture: tracks the address of each processor bus cycle,
// freezes it on an error, latches fault conditions and prioritises
// interrupt requests. Assumes all inputs synchronous to clk.
// Limitation: only the first error seen while tracking is kept; another
// capture needs a release first. Sources firing together are all kept
// in the cause field, so software sees every source of that cycle.
// Both latch groups give hardware set priority over software actions.
//
// Operation
// - On an error, freeze the address of the last cycle begun before it.
// - Memory ECC, bus parity and mate mismatch errors trigger capture.
// - Keep the captured address until the maintenance hold is released.
// - Latch interrupt requests, present the highest-priority pending one.
// - Latch fault conditions; processor may read, write and clear them.
`timescale 1ns/1ps
module fac_fault_address_capture #(
  parameter int ADDR_W = fac_pkg::FAC_ADDR_W,
  parameter int FAULT_W = fac_pkg::FAC_FAULT_W,
  parameter int IRQ_W = fac_pkg::FAC_IRQ_W,
  parameter int IRQ_ID_W = fac_pkg::FAC_IRQ_ID_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycleStart,
  input wire logic [ADDR_W-1:0] cycleAddr,
  input wire logic eccError,
  input wire logic parityError,
  input wire logic mismatchError,
  input wire logic holdRelease,
  output logic holdActive,
  output logic [ADDR_W-1:0] capturedAddr,
  output logic [fac_pkg::FAC_SRC_W-1:0] captureCause,
  input wire logic [FAULT_W-1:0] faultSet,
  input wire logic faultWrite,
  input wire logic [FAULT_W-1:0] faultWriteData,
  input wire logic faultClear,
  input wire logic [FAULT_W-1:0] faultClearMask,
  output logic [FAULT_W-1:0] faultLatch,
  input wire logic [IRQ_W-1:0] irqRequest,
  input wire logic irqAck,
  output logic irqPending,
  output logic [IRQ_ID_W-1:0] irqId
);
  import fac_pkg::*;

  fac_state_e state_q, state_d;
  logic [ADDR_W-1:0] lastAddr_q, lastAddr_d;
  logic [ADDR_W-1:0] holdAddr_q, holdAddr_d;
  logic [FAC_SRC_W-1:0] cause_q, cause_d;
  logic [FAULT_W-1:0] fault_q, fault_d;
  logic [IRQ_W-1:0] irq_q, irq_d;
  logic [IRQ_ID_W-1:0] irqId_q, irqId_d;
  logic irqPend_q, irqPend_d;
  logic [FAC_SRC_W-1:0] errVec;
  logic anyError;
  logic encAny;
  logic [IRQ_ID_W-1:0] encId;

  // Error vector; several sources may fire in one cycle and all are kept
  always_comb begin
    errVec = '0;
    errVec[FAC_SRC_ECC] = eccError;
    errVec[FAC_SRC_PARITY] = parityError;
    errVec[FAC_SRC_MISMATCH] = mismatchError;
    anyError = |errVec;
  end

  // Address tracker: follows every cycle start, whatever the hold does
  always_comb begin
    lastAddr_d = lastAddr_q;
    if (cycleStart) begin
      lastAddr_d = cycleAddr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lastAddr_q <= FAC_ADDR_RST[ADDR_W-1:0];
    end else begin
      lastAddr_q <= lastAddr_d;
    end
  end

  // Capture state; reads lastAddr_q, never lastAddr_d, so a cycle that
  // starts on the error edge itself is not the one frozen
  always_comb begin
    state_d = state_q;
    holdAddr_d = holdAddr_q;
    cause_d = cause_q;
    unique case (state_q)
      FAC_TRACK: begin
        // While tracking the hold register shadows the last started cycle
        holdAddr_d = lastAddr_q;
        if (anyError) begin
          holdAddr_d = lastAddr_q;
          cause_d = errVec;
          state_d = FAC_HOLD;
        end
      end
      FAC_HOLD: begin
        // Frozen: later errors, even beside the release, are ignored
        holdAddr_d = holdAddr_q;
        cause_d = cause_q;
        if (holdRelease) begin
          state_d = FAC_TRACK;
          cause_d = '0;
        end
      end
      default: begin
        // Illegal code: fall back to tracking with a clean cause
        state_d = FAC_TRACK;
        cause_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= FAC_TRACK;
      holdAddr_q <= FAC_ADDR_RST[ADDR_W-1:0];
      cause_q <= '0;
    end else begin
      state_q <= state_d;
      holdAddr_q <= holdAddr_d;
      cause_q <= cause_d;
    end
  end

  // Fault latches: hardware set wins over software clear or write
  always_comb begin
    fault_d = fault_q;
    if (faultWrite) begin
      fault_d = faultWriteData;
    end
    // A clear in the same cycle acts on the freshly written word
    if (faultClear) begin
      fault_d = fault_d & ~faultClearMask;
    end
    fault_d = fault_d | faultSet;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_q <= FAC_FAULT_RST[FAULT_W-1:0];
    end else begin
      fault_q <= fault_d;
    end
  end

  // Interrupt latch; a new request on the acked source wins over the ack
  always_comb begin
    irq_d = irq_q;
    if (irqAck && irqPend_q) begin
      // Only the source being presented is retired
      irq_d[irqId_q] = 1'b0;
    end
    irq_d = irq_d | irqRequest;
  end

  // Encoder looks at the next latch value so id and pending stay aligned
  fac_prio_enc #(
    .W(IRQ_W),
    .ID_W(IRQ_ID_W)
  ) irqEnc (
    .req(irq_d),
    .anyReq(encAny),
    .idx(encId)
  );

  always_comb begin
    irqPend_d = encAny;
    irqId_d = encId;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= FAC_IRQ_RST[IRQ_W-1:0];
      irqId_q <= '0;
      irqPend_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      irqId_q <= irqId_d;
      irqPend_q <= irqPend_d;
    end
  end

  // Every output except holdActive, a compare on state_q, comes straight from a register
  assign holdActive = (state_q == FAC_HOLD);
  assign capturedAddr = holdAddr_q;
  assign captureCause = cause_q;
  assign faultLatch = fault_q;
  assign irqPending = irqPend_q;
  assign irqId = irqId_q;
endmodule

// Priority encoder: flags any set request and gives the highest set
// index; the index is 0 when nothing is set, so read it with the flag.
module fac_prio_enc #(
  parameter int W = 8,
  parameter int ID_W = 3
) (
  input wire logic [W-1:0] req,
  output logic anyReq,
  output logic [ID_W-1:0] idx
);
  always_comb begin
    anyReq = |req;
    idx = '0;
    // Scan upwards so the highest set index is the last one written
    for (int i = 0; i < W; i++) begin
      if (req[i]) begin
        idx = ID_W'(i);
      end
    end
  end
endmodule

// ---- rtl/fac_pkg.sv ----
// Package for the fault address capture block: widths, source indices
// and reset values. Assumes a single clock with synchronous reset.
package fac_pkg;
  localparam int FAC_ADDR_W = 32;
  localparam int FAC_FAULT_W = 8;
  localparam int FAC_IRQ_W = 8;
  localparam int FAC_IRQ_ID_W = 3;
  localparam logic [FAC_ADDR_W-1:0] FAC_ADDR_RST = 32'h0000_0000;
  localparam logic [FAC_FAULT_W-1:0] FAC_FAULT_RST = 8'h00;
  localparam logic [FAC_IRQ_W-1:0] FAC_IRQ_RST = 8'h00;
  // Error source bit positions within the error vector
  localparam int FAC_SRC_ECC = 0;
  localparam int FAC_SRC_PARITY = 1;
  localparam int FAC_SRC_MISMATCH = 2;
  localparam int FAC_SRC_W = 3;
  typedef enum logic [1:0] {
    FAC_TRACK = 2'b01,
    FAC_HOLD = 2'b10
  } fac_state_e;
endpackage

// ---- test/fac_props.sv ----
// Port checker for the capture block; bound to its top module, one clock.
`timescale 1ns/1ps
module fac_props (
  input wire logic clk, rst_n, cycleStart, eccError, parityError,
  input wire logic mismatchError, holdRelease, holdActive, irqPending,
  input wire logic [31:0] cycleAddr, capturedAddr,
  input wire logic [2:0] captureCause,
  input wire logic [7:0] irqRequest, faultSet, faultLatch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [2:0] e = {mismatchError, parityError, eccError};
  wire logic h = holdActive;
  sequence s_ce; cycleStart ##1 |e && !h; endsequence
  property p_frz; s_ce |=> capturedAddr == $past(cycleAddr, 2); endproperty
  a_frz: assert property (p_frz) else $error("freeze");
  property p_cau; |e && !h |=> h && captureCause == $past(e); endproperty
  a_cau: assert property (p_cau) else $error("cause");
  property p_kp; h && !holdRelease |=> h && $stable(capturedAddr); endproperty
  a_kp: assert property (p_kp) else $error("hold");
  property p_ovr; h && |e && !holdRelease |=> $stable(captureCause); endproperty
  a_ovr: assert property (p_ovr) else $error("overwrite");
  property p_irq; |irqRequest |=> irqPending; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_flt;
    |faultSet |=> (faultLatch & $past(faultSet)) == $past(faultSet);
  endproperty
  a_flt: assert property (p_flt) else $error("fault");
endmodule
bind fac_fault_address_capture fac_props u_props (.*);

// ---- test/fac_host_model.sv ----
// Host processor model; acks and clears one clock after a bench request.
`timescale 1ns/1ps
module fac_host_model (
  input wire logic clk, ackReq, clrReq,
  output logic irqAck, faultClear
);
  always_ff @(posedge clk) {irqAck, faultClear} <= {ackReq, clrReq};
endmodule

// ---- test/tb_top.sv ----
// Bench for the capture block; the host model answers on the far side.
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n, cycleStart, eccError, parityError, mismatchError;
  logic holdRelease, holdActive, faultWrite, faultClear, irqAck, irqPending;
  logic ackReq, clrReq;
  logic [31:0] cycleAddr, capturedAddr;
  logic [31:0] rows [3] = '{32'h1000, 32'hffff_fffc, 32'h8000_0004};
  logic [2:0] captureCause, irqId;
  logic [7:0] faultSet, faultWriteData, faultClearMask, faultLatch, irqRequest;
  int bad_count, n_checks, cyc;
  fac_fault_address_capture DUT (.*);
  fac_host_model host (.*);
  initial forever #2 clk = ~clk;
  task automatic t(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string n, logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 300) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    {rst_n, cycleStart, eccError, parityError, mismatchError, holdRelease,
      faultWrite, ackReq, clrReq, cycleAddr, faultSet, faultWriteData,
      faultClearMask, irqRequest} = '0;
    t(6);
    rst_n <= 1;
    #1 chk("rst", {holdActive, captureCause, irqPending, faultLatch}, 32'h0);
    foreach (rows[i]) begin
      t(1);
      cycleStart <= 1;
      cycleAddr <= rows[i];
      t(1);
      // A new cycle on the error edge must not be the one captured
      cycleAddr <= ~rows[i];
      {mismatchError, parityError, eccError} <= 3'h1 << i;
      t(1);
      cycleStart <= 0;
      {mismatchError, parityError, eccError} <= 3'h7;
      t(1);
      {mismatchError, parityError, eccError, holdRelease} <= 4'h1;
      #1 chk("addr", capturedAddr, rows[i]);
      chk("cause", {holdActive, captureCause}, 4'h8 | 4'h1 << i);
      t(1);
      holdRelease <= 0;
      #1 chk("release", {holdActive, captureCause}, 32'h0);
    end
    irqRequest <= 8'h44;
    t(1);
    irqRequest <= 8'h00;
    ackReq <= 1;
    t(1);
    ackReq <= 0;
    #1 chk("irq", {irqPending, irqId}, 4'he);
    t(2);
    #1 chk("irqAck", {irqPending, irqId}, 4'ha);
    faultWrite <= 1;
    faultWriteData <= 8'h3c;
    clrReq <= 1;
    faultClearMask <= 8'h05;
    t(1);
    faultWrite <= 0;
    clrReq <= 0;
    faultSet <= 8'h01;
    t(1);
    faultSet <= 8'h00;
    #1 chk("fault", faultLatch, 8'h39);
    end_sim;
  end
endmodule
